// ==== rtl/bsa_pkg.sv ====
// Purpose: shared constants and opcodes of the binary add/sub unit
// Assumes: single clock, synchronous active-high reset
// Notes:   widths fixed at the documented values
package bsa_pkg;

  // ************************************************************
  // widths and reset values
  // ************************************************************
  localparam int          WORD_W    = 16;
  localparam int          DWORD_W   = 32;
  localparam int          ADDR_W    = 16;
  localparam logic [31:0] ACC_RST   = 32'h0000_0000;
  localparam logic        FLAG_RST  = 1'b0;
  localparam logic [15:0] ONE_WORD  = 16'h0001;
  localparam logic [31:0] K16_MAX   = 32'h0000_ffff;

  // ************************************************************
  // operation codes and operand sources
  // ************************************************************
  typedef enum logic [2:0] {
    BSA_OP_NONE,
    BSA_OP_ADD_BINARY_16,
    BSA_OP_ADD_BINARY_32,
    BSA_OP_SUB_BINARY_16,
    BSA_OP_SUB_BINARY_32,
    BSA_OP_DECREMENT_WORD,
    BSA_OP_LOAD
  } bsa_op_t;

  typedef enum logic [1:0] {
    BSA_SRC_WORD_MEM,
    BSA_SRC_POINTER,
    BSA_SRC_CONST
  } bsa_src_t;

  // ************************************************************
  // sequencer states
  // ************************************************************
  typedef enum logic [1:0] {
    BSA_ST_IDLE,
    BSA_ST_PTR,
    BSA_ST_LOW,
    BSA_ST_HIGH
  } bsa_state_t;

endpackage

// ==== rtl/bsa_word_mem.sv ====
// Purpose: word memory with registered read and one write port
// Assumes: read data appear the cycle after the address
// Notes:   depth fixed by address width
`timescale 1ns/1ps
module bsa_word_mem
(
  input  wire logic        clk,
  input  wire logic        wr_en,
  input  wire logic [15:0] wr_addr,
  input  wire logic [15:0] wr_data,
  input  wire logic [15:0] rd_addr,
  output logic      [15:0] rd_data
);

  logic [15:0] mem_q [0:(1 << bsa_pkg::ADDR_W) - 1];

  // ************************************************************
  // storage
  // ************************************************************
  always_ff @(posedge clk)
  begin
    if (wr_en)
    begin
      mem_q[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge clk)
  begin
    rd_data <= mem_q[rd_addr];
  end

endmodule

// ==== rtl/bsa_alu.sv ====
// Purpose: accumulator binary add/subtract unit with status flags
// Assumes: sequencer holds op_valid until op_done, or through the fetch for a decrement, which never raises op_done; inputs synchronous
// Notes:   memory operands cost extra cycles for the registered reads
//
// Behaviour
// - 16-bit add sums operand with accumulator low half, 32-bit result.
// - 16-bit operand from word memory, pointer word, or constant 0-ffff.
// - zero flag follows accumulator result after every add or subtract.
// - 16-bit add carry out sets the 16-bit carry flag.
// - 32-bit add carry out sets the 32-bit carry flag.
// - negative flag set when accumulator result is negative.
// - sign error flag set on signed overflow of an add.
// - 32-bit add sums full accumulator with 32-bit operand.
// - 16-bit subtract deducts operand from accumulator low half, keeps 16-bit difference.
// - 16-bit subtract borrow sets the 16-bit borrow flag.
// - 32-bit subtract borrow sets the 32-bit borrow flag.
// - 32-bit subtract deducts 32-bit operand from full accumulator.
// - 32-bit memory operand read from two consecutive words.
// - flags hold until the next instruction touching the same flag.
// - decrement lowers the addressed word by one each execution.
`timescale 1ns/1ps
module bsa_alu
(
  input  wire logic             clk,
  input  wire logic             reset,
  input  wire logic             op_valid,
  input  wire bsa_pkg::bsa_op_t  op_code,
  input  wire bsa_pkg::bsa_src_t op_src,
  input  wire logic [15:0]      op_addr,
  input  wire logic [31:0]      op_const,
  input  wire logic [31:0]      load_value,
  input  wire logic             mem_wr_en,
  input  wire logic [15:0]      mem_wr_addr,
  input  wire logic [15:0]      mem_wr_data,
  output logic                  op_done,
  output logic [31:0]           acc,
  output logic                  zero_flag,
  output logic                  borrow16_flag,
  output logic                  borrow32_flag,
  output logic                  carry16_flag,
  output logic                  carry32_flag,
  output logic                  negative_flag,
  output logic                  sign_error_flag
);

  bsa_pkg::bsa_state_t state_q;
  logic [15:0]         base_q;
  logic [15:0]         low_q;
  logic [15:0]         rd_addr;
  logic [15:0]         rd_data;
  logic                wr_en;
  logic [15:0]         wr_addr;
  logic [15:0]         wr_data;
  logic                dbl;
  logic                exec;
  logic [31:0]         operand;
  logic [32:0]         res;
  logic [16:0]         lo16;
  logic                ovf;

  assign dbl = (op_code == bsa_pkg::BSA_OP_ADD_BINARY_32)
            || (op_code == bsa_pkg::BSA_OP_SUB_BINARY_32);

  // ************************************************************
  // operand fetch sequence
  // ************************************************************
  // constants (except decrement) and loads execute in the first cycle, no memory wait
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      state_q <= bsa_pkg::BSA_ST_IDLE;
      base_q  <= 16'h0000;
      low_q   <= 16'h0000;
    end
    else
    begin
      unique case (state_q)
        bsa_pkg::BSA_ST_IDLE:
        begin
          if (op_valid && op_code != bsa_pkg::BSA_OP_NONE
              && op_code != bsa_pkg::BSA_OP_LOAD
              && (op_src != bsa_pkg::BSA_SRC_CONST
                  || op_code == bsa_pkg::BSA_OP_DECREMENT_WORD))
          begin
            base_q  <= op_addr;
            state_q <= (op_src == bsa_pkg::BSA_SRC_POINTER)
                     ? bsa_pkg::BSA_ST_PTR : bsa_pkg::BSA_ST_LOW;
          end
        end
        bsa_pkg::BSA_ST_PTR:
        begin
          base_q  <= rd_data;
          state_q <= bsa_pkg::BSA_ST_LOW;
        end
        bsa_pkg::BSA_ST_LOW:
        begin
          low_q   <= rd_data;
          state_q <= (dbl) ? bsa_pkg::BSA_ST_HIGH : bsa_pkg::BSA_ST_IDLE;
        end
        bsa_pkg::BSA_ST_HIGH:
        begin
          state_q <= bsa_pkg::BSA_ST_IDLE;
        end
      endcase
    end
  end

  // ************************************************************
  // memory addressing
  // ************************************************************
  always_comb
  begin
    rd_addr = op_addr;
    if (state_q == bsa_pkg::BSA_ST_PTR)
    begin
      rd_addr = rd_data;
    end
    else if (state_q == bsa_pkg::BSA_ST_LOW)
    begin
      rd_addr = base_q + bsa_pkg::ONE_WORD;
    end
    else if (state_q != bsa_pkg::BSA_ST_IDLE)
    begin
      rd_addr = base_q;
    end
  end

  // reads issue one cycle ahead of use
  logic [15:0] pre_addr;
  assign pre_addr = (state_q == bsa_pkg::BSA_ST_IDLE
                     && op_src == bsa_pkg::BSA_SRC_POINTER) ? op_addr
                  : (state_q == bsa_pkg::BSA_ST_PTR) ? rd_data
                  : (state_q == bsa_pkg::BSA_ST_LOW) ? base_q
                                                       + bsa_pkg::ONE_WORD
                  : op_addr;

  // ************************************************************
  // execution
  // ************************************************************
  always_comb
  begin
    exec = 1'b0;
    if (op_valid)
    begin
      if (state_q == bsa_pkg::BSA_ST_IDLE)
      begin
        exec = (op_code == bsa_pkg::BSA_OP_LOAD)
            || (op_code != bsa_pkg::BSA_OP_NONE
                && op_code != bsa_pkg::BSA_OP_DECREMENT_WORD
                && op_src == bsa_pkg::BSA_SRC_CONST);
      end
      else if (state_q == bsa_pkg::BSA_ST_LOW)
      begin
        // decrement only writes back, never loads the accumulator
        exec = !dbl && op_code != bsa_pkg::BSA_OP_DECREMENT_WORD;
      end
      else if (state_q == bsa_pkg::BSA_ST_HIGH)
      begin
        exec = 1'b1;
      end
    end
  end
  assign op_done = exec;

  always_comb
  begin
    operand = 32'h0000_0000;
    if (state_q == bsa_pkg::BSA_ST_IDLE)
    begin
      operand = dbl ? op_const : (op_const & bsa_pkg::K16_MAX);
    end
    else if (state_q == bsa_pkg::BSA_ST_HIGH)
    begin
      // low word first, high word second
      operand = {rd_data, low_q};
    end
    else
    begin
      operand = {16'h0000, rd_data};
    end
  end

  always_comb
  begin
    res  = 33'h0_0000_0000;
    lo16 = 17'h0_0000;
    ovf  = 1'b0;
    unique case (op_code)
      bsa_pkg::BSA_OP_ADD_BINARY_16:
      begin
        // low half plus operand, 32-bit result
        lo16 = {1'b0, acc[15:0]} + {1'b0, operand[15:0]};
        res  = {16'h0000, lo16};
        ovf  = (acc[15] == operand[15]) && (lo16[15] != acc[15]);
      end
      bsa_pkg::BSA_OP_ADD_BINARY_32:
      begin
        res = {1'b0, acc} + {1'b0, operand};
        ovf = (acc[31] == operand[31]) && (res[31] != acc[31]);
      end
      bsa_pkg::BSA_OP_SUB_BINARY_16:
      begin
        lo16 = {1'b0, acc[15:0]} - {1'b0, operand[15:0]};
        res  = {17'h0_0000, lo16[15:0]};
      end
      bsa_pkg::BSA_OP_SUB_BINARY_32:
      begin
        res = {1'b0, acc} - {1'b0, operand};
      end
      default:
      begin
        res = {1'b0, load_value};
      end
    endcase
  end

  // ************************************************************
  // accumulator and flags
  // ************************************************************
  logic is_arith;
  assign is_arith = (op_code == bsa_pkg::BSA_OP_ADD_BINARY_16)
                 || (op_code == bsa_pkg::BSA_OP_ADD_BINARY_32)
                 || (op_code == bsa_pkg::BSA_OP_SUB_BINARY_16)
                 || (op_code == bsa_pkg::BSA_OP_SUB_BINARY_32);

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      acc <= bsa_pkg::ACC_RST;
    end
    else if (exec)
    begin
      acc <= res[31:0];
    end
  end

  // only flags of this op change
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      zero_flag       <= bsa_pkg::FLAG_RST;
      negative_flag   <= bsa_pkg::FLAG_RST;
      carry16_flag    <= bsa_pkg::FLAG_RST;
      carry32_flag    <= bsa_pkg::FLAG_RST;
      borrow16_flag   <= bsa_pkg::FLAG_RST;
      borrow32_flag   <= bsa_pkg::FLAG_RST;
      sign_error_flag <= bsa_pkg::FLAG_RST;
    end
    else if (exec && is_arith)
    begin
      zero_flag     <= (res[31:0] == 32'h0000_0000);
      negative_flag <= res[31];
      if (op_code == bsa_pkg::BSA_OP_ADD_BINARY_16
          || op_code == bsa_pkg::BSA_OP_ADD_BINARY_32)
      begin
        carry16_flag <= (op_code == bsa_pkg::BSA_OP_ADD_BINARY_16)
                        ? lo16[16]
                        : (({1'b0, acc[15:0]} + {1'b0, operand[15:0]})
                           > 17'h0_ffff);
        carry32_flag    <= (op_code == bsa_pkg::BSA_OP_ADD_BINARY_32)
                           && res[32];
        sign_error_flag <= ovf;
      end
      else
      begin
        borrow16_flag <= (op_code == bsa_pkg::BSA_OP_SUB_BINARY_16)
                         ? (operand[15:0] > acc[15:0])
                         : (operand[15:0] > acc[15:0]);
        borrow32_flag <= (op_code == bsa_pkg::BSA_OP_SUB_BINARY_32)
                         && (operand > acc);
      end
    end
  end

  // ************************************************************
  // decrement write-back and memory
  // ************************************************************
  // one decrement per execution; left to the sequencer
  always_comb
  begin
    wr_en   = mem_wr_en;
    wr_addr = mem_wr_addr;
    wr_data = mem_wr_data;
    if (op_valid && op_code == bsa_pkg::BSA_OP_DECREMENT_WORD
        && state_q == bsa_pkg::BSA_ST_LOW)
    begin
      wr_en   = 1'b1;
      wr_addr = base_q;
      wr_data = rd_data - bsa_pkg::ONE_WORD;
    end
  end

  bsa_word_mem u_mem
  (
    .clk     (clk),
    .wr_en   (wr_en),
    .wr_addr (wr_addr),
    .wr_data (wr_data),
    .rd_addr ((state_q == bsa_pkg::BSA_ST_IDLE) ? pre_addr : rd_addr),
    .rd_data (rd_data)
  );

endmodule

// ==== dv/bsa_alu_asserts.sv ====
// Purpose: port checks of the add/sub unit
// Assumes: arithmetic checked on constant operands
// Notes:   memory contents are not visible here
`timescale 1ns/1ps
module bsa_alu_asserts
(
  input wire logic              clk,
  input wire logic              reset,
  input wire logic              op_valid,
  input wire bsa_pkg::bsa_op_t  op_code,
  input wire bsa_pkg::bsa_src_t op_src,
  input wire logic [31:0]       op_const,
  input wire logic              op_done,
  input wire logic [31:0]       acc,
  input wire logic              borrow16_flag,
  input wire logic              borrow32_flag,
  input wire logic              carry16_flag,
  input wire logic              carry32_flag,
  input wire logic              zero_flag,
  input wire logic              negative_flag,
  input wire logic              sign_error_flag
);
  // ****
  // helpers
  // ****
  wire k   = op_src == bsa_pkg::BSA_SRC_CONST;
  wire a16 = op_code == bsa_pkg::BSA_OP_ADD_BINARY_16;
  wire a32 = op_code == bsa_pkg::BSA_OP_ADD_BINARY_32;
  wire s16 = op_code == bsa_pkg::BSA_OP_SUB_BINARY_16;
  wire s32 = op_code == bsa_pkg::BSA_OP_SUB_BINARY_32;
  wire ar  = a16 | a32 | s16 | s32;
  default clocking @(posedge clk);
  endclocking
  default disable iff (reset);
  sequence s_mem32;
    !op_done [*2] ##1 op_done;
  endsequence
  AST_ADD16: assert property (op_done && a16 && k |=>
    acc == 32'($past(acc[15:0])) + 32'($past(op_const[15:0])))
    else $error("add16 sum wrong");
  AST_CARRY16: assert property (op_done && a16 && k |=>
    carry16_flag == (32'($past(acc[15:0])) + 32'($past(op_const[15:0]))
    > 32'hffff)) else $error("carry16 wrong");
  AST_ADD32: assert property (op_done && a32 && k |=>
    {carry32_flag, acc} == {1'b0, $past(acc)} + {1'b0, $past(op_const)})
    else $error("add32 sum or carry wrong");
  AST_SUB32: assert property (op_done && s32 && k |=>
    acc == $past(acc) - $past(op_const)
    && borrow32_flag == ($past(op_const) > $past(acc)))
    else $error("sub32 wrong");
  AST_BORROW16: assert property (op_done && s16 && k |=>
    borrow16_flag == ($past(op_const[15:0]) > $past(acc[15:0])))
    else $error("borrow16 wrong");
  AST_ZERO: assert property (op_done && ar |=> zero_flag == (acc == 0))
    else $error("zero flag wrong");
  AST_NEG: assert property (op_done && ar |=> negative_flag == acc[31])
    else $error("negative flag wrong");
  AST_SIGN: assert property (op_done && a32 && k |=>
    sign_error_flag == ($past(acc[31]) == $past(op_const[31])
    && acc[31] != $past(acc[31]))) else $error("sign error wrong");
  AST_HOLD: assert property (op_done && (s16 | s32) |=>
    $stable(carry32_flag) && $stable(sign_error_flag))
    else $error("untouched flag changed");
  AST_KDONE: assert property ($rose(op_valid) && k && ar |-> op_done)
    else $error("const op not done at once");
  AST_MEM32: assert property ($rose(op_valid) && a32
    && op_src == bsa_pkg::BSA_SRC_WORD_MEM |-> s_mem32)
    else $error("mem32 latency wrong");
endmodule

// ==== dv/bsa_seq_model.sv ====
// Purpose: instruction sequencer model
// Assumes: inputs change at the falling edge
// Notes:   released operands are scrambled
`timescale 1ns/1ps
module bsa_seq_model
(
  input  wire logic         clk,
  input  wire logic         op_done,
  output logic              op_valid,
  output bsa_pkg::bsa_op_t  op_code,
  output bsa_pkg::bsa_src_t op_src,
  output logic [15:0]       op_addr,
  output logic [31:0]       op_const,
  output logic [31:0]       load_value,
  output logic              mem_wr_en,
  output logic [15:0]       mem_wr_addr,
  output logic [15:0]       mem_wr_data
);
  int lost = 0;
  initial
  begin
    {op_valid, mem_wr_en} = 2'h0;
    op_code = bsa_pkg::BSA_OP_NONE;
    op_src = bsa_pkg::BSA_SRC_CONST;
    {op_addr, op_const, load_value} = 80'h0;
    {mem_wr_addr, mem_wr_data} = 32'h0;
  end
  // hold until done is seen at a rising edge, then release
  task automatic issue(input bsa_pkg::bsa_op_t c, bsa_pkg::bsa_src_t s,
                       logic [15:0] a, logic [31:0] v);
    int n;
    n = 0;
    @(negedge clk);
    op_code = c;
    op_src = s;
    {op_addr, op_const, load_value} = {a, v, v};
    op_valid = 1'b1;
    @(posedge clk);
    while (op_done !== 1'b1 && n < 8)
    begin
      n++;
      @(posedge clk);
    end
    if (op_done !== 1'b1)
      lost++;
    @(negedge clk);
    op_valid = 1'b0;
    {op_addr, op_const, load_value} = ~{a, v, v};
  endtask
  // one request per closure, held through the fetch
  task automatic dec(input logic [15:0] a);
    @(negedge clk);
    op_code = bsa_pkg::BSA_OP_DECREMENT_WORD;
    op_src = bsa_pkg::BSA_SRC_WORD_MEM;
    op_addr = a;
    op_valid = 1'b1;
    repeat (2) @(negedge clk);
    op_valid = 1'b0;
    op_addr = ~a;
  endtask
  task automatic wr(input logic [15:0] a, d);
    @(negedge clk);
    {mem_wr_en, mem_wr_addr, mem_wr_data} = {1'b1, a, d};
    @(negedge clk);
    {mem_wr_en, mem_wr_addr, mem_wr_data} = {1'b0, ~a, ~d};
  endtask
endmodule

// ==== dv/testbench.sv ====
// Purpose: directed bench of the add/sub unit
// Assumes: sequencer model drives all requests
// Notes:   flags checked under a mask per step
`timescale 1ns/1ps
module testbench;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic op_valid, mem_wr_en, op_done;
  bsa_pkg::bsa_op_t op_code;
  bsa_pkg::bsa_src_t op_src;
  logic [15:0] op_addr, mem_wr_addr, mem_wr_data;
  logic [31:0] op_const, load_value, acc;
  logic z, b16, b32, c16, c32, ng, se;
  int num_errors = 0;
  int checks_done = 0;
  int cyc = 0;
  localparam bsa_pkg::bsa_src_t k = bsa_pkg::BSA_SRC_CONST;
  always #25 clk = ~clk;
  bsa_alu dut_u
  (
    .clk(clk), .reset(reset), .op_valid(op_valid), .op_code(op_code),
    .op_src(op_src), .op_addr(op_addr), .op_const(op_const),
    .load_value(load_value), .mem_wr_en(mem_wr_en),
    .mem_wr_addr(mem_wr_addr), .mem_wr_data(mem_wr_data),
    .op_done(op_done), .acc(acc), .zero_flag(z), .borrow16_flag(b16),
    .borrow32_flag(b32), .carry16_flag(c16), .carry32_flag(c32),
    .negative_flag(ng), .sign_error_flag(se)
  );
  bsa_seq_model seq_u
  (
    .clk(clk), .op_done(op_done), .op_valid(op_valid), .op_code(op_code),
    .op_src(op_src), .op_addr(op_addr), .op_const(op_const),
    .load_value(load_value), .mem_wr_en(mem_wr_en),
    .mem_wr_addr(mem_wr_addr), .mem_wr_data(mem_wr_data)
  );
  task automatic chk(input logic [31:0] g, e);
    checks_done++;
    if (g !== e)
    begin
      num_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // flag order: zero b16 b32 c16 c32 negative sign
  task automatic chkf(input logic [6:0] m, e);
    chk(32'({z, b16, b32, c16, c32, ng, se} & m), 32'(e));
  endtask
  task automatic ldop(input logic [31:0] l, bsa_pkg::bsa_op_t c,
                      bsa_pkg::bsa_src_t s, logic [15:0] a, logic [31:0] v);
    seq_u.issue(bsa_pkg::BSA_OP_LOAD, k, 16'h0, l);
    seq_u.issue(c, s, a, v);
  endtask
  task automatic test_done;
    num_errors += seq_u.lost;
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      num_errors++;
      test_done();
    end
  end
  initial
  begin
    repeat (12) @(negedge clk);
    reset = 1'b0;
    chk(acc, 32'h0);
    chkf(7'h7f, 7'h0);
    ldop(32'h0000_ffff, bsa_pkg::BSA_OP_ADD_BINARY_16, k, 16'h0, 32'h1);
    chk(acc, 32'h0001_0000);
    chkf(7'b1001011, 7'b0001000);
    ldop(32'hffff_ffff, bsa_pkg::BSA_OP_ADD_BINARY_32, k, 16'h0, 32'h1);
    chkf(7'b1000101, 7'b1000100);
    ldop(32'h7fff_ffff, bsa_pkg::BSA_OP_ADD_BINARY_32, k, 16'h0, 32'h1);
    chk(acc, 32'h8000_0000);
    chkf(7'b1000111, 7'b0000011);
    ldop(32'h5, bsa_pkg::BSA_OP_SUB_BINARY_16, k, 16'h0, 32'h6);
    chk(acc, 32'h0000_ffff);
    chkf(7'b1100101, 7'b0100001);
    seq_u.wr(16'h0010, 16'h0300);
    seq_u.wr(16'h0300, 16'h0002);
    seq_u.wr(16'h0301, 16'h0000);
    ldop(32'h1, bsa_pkg::BSA_OP_SUB_BINARY_32, bsa_pkg::BSA_SRC_POINTER,
         16'h0010, 32'h0);
    chk(acc, 32'hffff_ffff);
    chkf(7'b1010010, 7'b0010010);
    seq_u.wr(16'h0100, 16'h5678);
    seq_u.wr(16'h0101, 16'h1234);
    ldop(32'h0, bsa_pkg::BSA_OP_ADD_BINARY_32, bsa_pkg::BSA_SRC_WORD_MEM,
         16'h0100, 32'h0);
    chk(acc, 32'h1234_5678);
    seq_u.wr(16'h0200, 16'h0000);
    seq_u.dec(16'h0200);
    seq_u.dec(16'h0200);
    ldop(32'h0, bsa_pkg::BSA_OP_ADD_BINARY_16, bsa_pkg::BSA_SRC_WORD_MEM,
         16'h0200, 32'h0);
    chk(acc, 32'h0000_fffe);
    seq_u.issue(bsa_pkg::BSA_OP_SUB_BINARY_16, k, 16'h0, 32'h0000_fffe);
    chk(acc, 32'h0);
    chkf(7'b1101000, 7'b1000000);
    test_done();
  end
endmodule
bind bsa_alu bsa_alu_asserts chk_u
(
  .clk(clk), .reset(reset), .op_valid(op_valid), .op_code(op_code),
  .op_src(op_src), .op_const(op_const), .op_done(op_done), .acc(acc),
  .borrow16_flag(borrow16_flag), .borrow32_flag(borrow32_flag),
  .carry16_flag(carry16_flag), .carry32_flag(carry32_flag),
  .zero_flag(zero_flag), .negative_flag(negative_flag),
  .sign_error_flag(sign_error_flag)
);
